// ==== csc_regs.vh ====
// constants of the charge status controller
`ifndef CSC_REGS_VH
`define CSC_REGS_VH
`define CSC_CLK_HZ          100000000
`define CSC_TICK_US         1000
`define CSC_TICK_CYC        ((`CSC_CLK_HZ / 1000000) * `CSC_TICK_US)
`define CSC_DEGLITCH_MS     25
`define CSC_DEGLITCH_TICKS  (`CSC_DEGLITCH_MS * 1000 / `CSC_TICK_US)
`define CSC_DEGLITCH_LAST   5'h18
`define CSC_BLINK_MS        500
`define CSC_BLINK_TICKS     (`CSC_BLINK_MS * 1000 / `CSC_TICK_US)
`define CSC_BLINK_LAST      16'h01f3
`define CSC_TIMEOUT_MIN     300
`define CSC_TIMEOUT_TICKS   (`CSC_TIMEOUT_MIN * 60 * (1000000 / `CSC_TICK_US))
`define CSC_DG_W            5
`define CSC_ST_OFF          3'h0
`define CSC_ST_TRICKLE      3'h1
`define CSC_ST_FAST_CC      3'h2
`define CSC_ST_CV           3'h3
`define CSC_ST_DONE         3'h4
`define CSC_ST_FAULT        3'h5
`define CSC_EOC_TENTH       1'b0
`define CSC_EOC_THIRTIETH   1'b1
`endif

// ==== csc_deglitch.v ====
// deglitch filter for one indicator level, counts timebase ticks
`timescale 1ns/1ps
`default_nettype none
`include "csc_regs.vh"
module csc_deglitch (
    input  wire                  core_clk,
    input  wire                  rst,
    input  wire                  tick,
    input  wire                  raw,
    output reg                   filtered
);
    reg [`CSC_DG_W-1:0] count;

    // raw must hold its new level for the full delay, both edges alike
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count    <= {`CSC_DG_W{1'b0}};
            filtered <= 1'b0;
        end else if (raw == filtered) begin
            count <= {`CSC_DG_W{1'b0}};
        end else if (tick) begin
            if (count == `CSC_DEGLITCH_LAST) begin
                filtered <= raw;
                count    <= {`CSC_DG_W{1'b0}};
            end else begin
                count <= count + 1'b1;
            end
        end
    end
endmodule // csc_deglitch
`default_nettype wire

// ==== csc_charge_ctrl.v ====
// charge phase, indicator and power path control of a one-cell charger
// Summary of operation
// - rail target 3.4V below 3.2V, else battery+225mV
// - trickle below 3.0V, fast current above
// - at 4.2V switch to constant voltage
// - status low at trickle start, released at done
// - termination 10% normally, 3.3% low-power usb
// - supply good only inside input window
// - done needs above recharge level, low current
// - released status stays off through recharges
// - 25ms deglitch on both status edges; the fault blink bypasses it
// - recharge clears safety timer, restarts charging
// - timeout before done blinks status every 0.5s
// - timeout fault cleared only by power cycle
// - rail stays supplied in done and fault
// - select low terminates; high disables, strap at reset
// - select high suspends the safety timer
// - low current releases status regardless of select
// - rail 100mV low engages path sharing
// - rail 40mV under battery turns battery switch on
// - sag throttle only for usb source settings
// - input overvoltage disables charging
`timescale 1ns/1ps
`default_nettype none
`include "csc_regs.vh"
module csc_charge_ctrl #(
    parameter integer TICK_CYC      = `CSC_TICK_CYC,
    parameter integer TIMEOUT_TICKS = `CSC_TIMEOUT_TICKS
) (
    input  wire                  core_clk,
    input  wire                  rst,
    input  wire                  vin_above_por,
    input  wire                  vin_above_headroom,
    input  wire                  input_overvoltage,
    input  wire                  vbat_above_3v0,
    input  wire                  vbat_above_3v2,
    input  wire                  vbat_at_4v2,
    input  wire                  vbat_above_recharge,
    input  wire                  ibat_below_termination,
    input  wire                  battery_present,
    input  wire                  rail_below_sharing,
    input  wire                  rail_below_battery,
    input  wire                  charge_enable_n,
    input  wire                  termination_select,
    input  wire                  source_type_select,
    input  wire                  usb_mode,
    output reg                   charge_status_n_out,
    output reg                   charge_status_n_oe,
    output reg                   supply_good_n_out,
    output reg                   supply_good_n_oe,
    output reg                   rail_target_fixed,
    output reg                   charge_on,
    output reg                   trickle_current,
    output reg                   cv_mode,
    output reg                   termination_ratio,
    output reg                   path_sharing,
    output reg                   battery_path_switch,
    output reg                   input_sag_throttle,
    output reg                   timeout_fault,
    output reg  [2:0]            phase
);
    ////////////////////////////////////////////////////////////////////////
    // shared timebase: one tick per millisecond
    reg [31:0] prescale;
    reg        tick;

    // every long delay counts these ticks so all scale together
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prescale <= 32'h0000_0000;
            tick     <= 1'b0;
        end else if (prescale == TICK_CYC - 1) begin
            prescale <= 32'h0000_0000;
            tick     <= 1'b1;
        end else begin
            prescale <= prescale + 32'h0000_0001;
            tick     <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // input window and straps
    wire power_ok = vin_above_por & vin_above_headroom & ~input_overvoltage;
    reg  power_ok_q;
    reg  strap_taken;
    reg  term_disabled;
    reg  enable_q;
    reg  present_q;

    // strap sampled once after reset release; later changes ignored
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            strap_taken   <= 1'b0;
            term_disabled <= 1'b0;
            power_ok_q    <= 1'b0;
            enable_q      <= 1'b0;
            present_q     <= 1'b0;
        end else begin
            power_ok_q <= power_ok;
            enable_q   <= ~charge_enable_n;
            present_q  <= battery_present;
            if (!strap_taken) begin
                strap_taken   <= 1'b1;
                term_disabled <= termination_select;
            end
        end
    end

    wire power_cycled = power_ok & ~power_ok_q;
    wire enable_edge  = enable_q ^ ~charge_enable_n;
    wire reinsert     = battery_present & ~present_q;
    wire charge_allow = power_ok & ~charge_enable_n & battery_present;

    ////////////////////////////////////////////////////////////////////////
    // phase machine
    localparam [2:0] ST_OFF   = `CSC_ST_OFF;
    localparam [2:0] ST_TRK   = `CSC_ST_TRICKLE;
    localparam [2:0] ST_CC    = `CSC_ST_FAST_CC;
    localparam [2:0] ST_CV    = `CSC_ST_CV;
    localparam [2:0] ST_DONE  = `CSC_ST_DONE;
    localparam [2:0] ST_FAULT = `CSC_ST_FAULT;

    ////////////////////////////////////////////////////////////////////////
    // state and source decoding shared by several processes
    // one decoder per question keeps the timer, latch and outputs in step

    // the three phases in which current flows into the battery
    function is_charging(input [2:0] st);
        is_charging = (st == `CSC_ST_TRICKLE) |
                      (st == `CSC_ST_FAST_CC) |
                      (st == `CSC_ST_CV);
    endfunction

    // fault is the only state that owns the status pin outright
    function is_fault(input [2:0] st);
        is_fault = (st == `CSC_ST_FAULT);
    endfunction

    // the low-power usb setting is source 0 with mode 0
    // it alone gets the finer termination ratio
    function low_power_usb(input source, input mode);
        low_power_usb = ~source & ~mode;
    endfunction

    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg  [31:0] safety;
    reg         fault;
    reg         status_latched;
    reg         blink;
    reg  [15:0] blink_cnt;

    wire eoc_seen = vbat_above_recharge & ibat_below_termination;
    wire timed_out = (safety == TIMEOUT_TICKS - 1) & tick;
    wire charging  = is_charging(state);

    // phase by battery level; done only when termination enabled
    always @* begin
        next_state = state;
        case (state)
            ST_OFF: begin
                if (charge_allow & ~fault)
                    next_state = vbat_above_3v0 ? ST_CC : ST_TRK;
            end
            ST_TRK: begin
                if (vbat_above_3v0)
                    next_state = ST_CC;
            end
            ST_CC: begin
                if (vbat_at_4v2)
                    next_state = ST_CV;
            end
            ST_CV: begin
                if (eoc_seen & ~term_disabled)
                    next_state = ST_DONE;
            end
            ST_DONE: begin
                if (~vbat_above_recharge)
                    next_state = vbat_above_3v0 ? ST_CC : ST_TRK;
            end
            ST_FAULT: begin
                next_state = ST_FAULT;
            end
            default: next_state = ST_OFF;
        endcase
        if (state != ST_FAULT) begin
            if (~charge_allow)
                next_state = ST_OFF;
            else if (charging & timed_out & ~term_disabled)
                next_state = ST_FAULT;
        end
        if (power_cycled)
            next_state = ST_OFF;
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst)
            state <= ST_OFF;
        else
            state <= next_state;
    end

    // fault holds until input power returns after removal
    always @(posedge core_clk or posedge rst) begin
        if (rst)
            fault <= 1'b0;
        else if (power_cycled)
            fault <= 1'b0;
        else if (next_state == ST_FAULT)
            fault <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // safety timer: cleared on recharge, frozen while termination disabled
    always @(posedge core_clk or posedge rst) begin
        if (rst)
            safety <= 32'h0000_0000;
        else if (~charging | (state == ST_DONE & next_state != ST_DONE))
            safety <= 32'h0000_0000;
        else if (tick & ~term_disabled)
            safety <= safety + 32'h0000_0001;
    end

    // half-second blink for the fault indication
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            blink_cnt <= 16'h0000;
            blink     <= 1'b0;
        end else if (~is_fault(state)) begin
            blink_cnt <= 16'h0000;
            blink     <= 1'b0;
        end else if (tick) begin
            if (blink_cnt == `CSC_BLINK_LAST) begin
                blink_cnt <= 16'h0000;
                blink     <= ~blink;
            end else begin
                blink_cnt <= blink_cnt + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status latch: off at end of charge, rearmed by three events
    always @(posedge core_clk or posedge rst) begin
        if (rst)
            status_latched <= 1'b0;
        else if (charging & eoc_seen)
            status_latched <= 1'b1;
        else if (power_cycled | enable_edge | reinsert)
            status_latched <= 1'b0;
    end

    // raw drive request: pull low while charging unless latched off
    wire status_raw = is_fault(state) ? blink :
                      (charging & ~status_latched);
    wire status_drive;

    // blink bypasses the filter, which would otherwise delay each of its edges by 25 ticks
    csc_deglitch u_status_dg (
        .core_clk (core_clk),
        .rst      (rst),
        .tick     (tick),
        .raw      (status_raw),
        .filtered (status_drive)
    );

    ////////////////////////////////////////////////////////////////////////
    // next values of the registered outputs
    reg next_status_oe;
    reg next_good_oe;
    reg next_rail_fixed;
    reg next_charge_on;
    reg next_trickle;
    reg next_cv;
    reg next_ratio;
    reg next_sharing;
    reg next_switch;
    reg next_throttle;

    // every output but timeout_fault, phase, charge_status_n_out and supply_good_n_out is decided here and only copied by the flops below,
    // so each pin changes exactly one clock after its cause
    always @* begin
        // blink owns the pin in fault; the filter would stretch its edges
        next_status_oe  = is_fault(state) ? blink : status_drive;
        next_good_oe    = power_ok;
        next_rail_fixed = ~vbat_above_3v2;
        next_charge_on  = charging;
        // phase flags mirror the state one for one
        next_trickle    = state == ST_TRK;
        next_cv         = state == ST_CV;
        next_ratio      = `CSC_EOC_TENTH;
        if (low_power_usb(source_type_select, usb_mode))
            next_ratio = `CSC_EOC_THIRTIETH;
        // load comes first; charging only takes what is left
        next_sharing    = power_ok & rail_below_sharing;
        // rail served in every state; battery backs it when short
        next_switch     = charging | rail_below_battery;
        // only the usb settings may throttle on input sag
        next_throttle   = ~source_type_select;
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            charge_status_n_out <= 1'b0;
            charge_status_n_oe  <= 1'b0;
            supply_good_n_out   <= 1'b0;
            supply_good_n_oe    <= 1'b0;
            rail_target_fixed   <= 1'b1;
            charge_on           <= 1'b0;
            trickle_current     <= 1'b0;
            cv_mode             <= 1'b0;
            termination_ratio   <= `CSC_EOC_TENTH;
            path_sharing        <= 1'b0;
            battery_path_switch <= 1'b0;
            input_sag_throttle  <= 1'b0;
            timeout_fault       <= 1'b0;
            phase               <= `CSC_ST_OFF;
        end else begin
            charge_status_n_out <= 1'b0;
            charge_status_n_oe  <= next_status_oe;
            supply_good_n_out   <= 1'b0;
            supply_good_n_oe    <= next_good_oe;
            rail_target_fixed   <= next_rail_fixed;
            charge_on           <= next_charge_on;
            trickle_current     <= next_trickle;
            cv_mode             <= next_cv;
            termination_ratio   <= next_ratio;
            path_sharing        <= next_sharing;
            battery_path_switch <= next_switch;
            input_sag_throttle  <= next_throttle;
            timeout_fault       <= fault;
            phase               <= state;
        end
    end
endmodule // csc_charge_ctrl
`default_nettype wire

// ==== csc_checker.sv ====
// port checker for the charge status controller
`timescale 1ns/1ps
`default_nettype none
module csc_checker #(
    parameter integer TICK_CYC = 10
) (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       vin_above_por,
    input wire logic       vin_above_headroom,
    input wire logic       input_overvoltage,
    input wire logic       vbat_above_3v0,
    input wire logic       vbat_above_3v2,
    input wire logic       vbat_at_4v2,
    input wire logic       termination_select,
    input wire logic       source_type_select,
    input wire logic       usb_mode,
    input wire logic       charge_status_n_oe,
    input wire logic       supply_good_n_oe,
    input wire logic       rail_target_fixed,
    input wire logic       charge_on,
    input wire logic       trickle_current,
    input wire logic       cv_mode,
    input wire logic       termination_ratio,
    input wire logic       input_sag_throttle,
    input wire logic       timeout_fault,
    input wire logic [2:0] phase
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire         pg_ok;
    assign pg_ok = vin_above_por & vin_above_headroom & ~input_overvoltage;
    logic [15:0] since_chg;
    logic        first;
    logic        strap;
    ////////////////////////////////////////
    // status age saturates so long holds never wrap into a false short gap
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            since_chg <= 16'h0000;
            first <= 1'b1;
            strap <= 1'b0;
        end else begin
            if ($changed(charge_status_n_oe))
                since_chg <= 16'h0000;
            else if (since_chg != 16'hffff)
                since_chg <= since_chg + 16'h0001;
            first <= 1'b0;
            if (first)
                strap <= termination_select;
        end
    end
    ////////////////////////////////////////
    a_rail_target: assert property (
        $stable(vbat_above_3v2) [*3] |-> rail_target_fixed == !vbat_above_3v2)
        else $error("rail target does not follow battery level");
    a_supply_window: assert property (
        $stable(pg_ok) [*3] |-> supply_good_n_oe == pg_ok)
        else $error("supply good outside input window");
    a_ovp_blocks: assert property (
        input_overvoltage [*3] |-> !charge_on)
        else $error("charging during input overvoltage");
    a_sag_usb: assert property (
        $stable(source_type_select) [*3]
        |-> input_sag_throttle == !source_type_select)
        else $error("sag throttle in wrong source setting");
    a_term_ratio: assert property (
        $stable({source_type_select, usb_mode}) [*3]
        |-> termination_ratio == (!source_type_select && !usb_mode))
        else $error("termination ratio wrong for source");
    a_trickle_below: assert property (
        vbat_above_3v0 [*3] |-> !trickle_current)
        else $error("trickle current above trickle level");
    a_cv_cause: assert property (
        $rose(cv_mode) |-> $past(vbat_at_4v2) || $past(vbat_at_4v2, 2))
        else $error("constant voltage without final level");
    a_status_deglitch: assert property (
        $changed(charge_status_n_oe) && !timeout_fault
        && !$past(timeout_fault, 3) |-> since_chg >= 24 * TICK_CYC)
        else $error("status moved before deglitch time");
    a_fault_sticky: assert property (
        pg_ok [*4] ##0 timeout_fault |=> timeout_fault)
        else $error("fault cleared without power cycle");
    a_strap_timer: assert property (
        !first && strap |-> !timeout_fault)
        else $error("timeout while termination disabled");
    a_fault_stops: assert property (
        timeout_fault [*2] |-> phase == 3'h5 && !charge_on)
        else $error("charging goes on after timeout");
    c_fault: cover property ($rose(timeout_fault));
    c_done: cover property (phase == 3'h4);
    c_cv: cover property (cv_mode);
endmodule // csc_checker
`default_nettype wire

// ==== csc_led_model.sv ====
// open-drain indicator pins as seen by a gpio with pull-ups
`timescale 1ns/1ps
`default_nettype none
module csc_led_model (
    input  wire logic status_oe,
    input  wire logic status_drv,
    input  wire logic good_oe,
    input  wire logic good_drv,
    output wire logic status_pin,
    output wire logic good_pin
);
    // a released pin floats up through its pull-up, never holds its last level
    assign status_pin = status_oe ? status_drv : 1'b1;
    assign good_pin = good_oe ? good_drv : 1'b1;
endmodule // csc_led_model
`default_nettype wire

// ==== csc_charge_ctrl_tb.sv ====
// self-checking bench of the charge status controller
`timescale 1ns/1ps
`default_nettype none
module csc_charge_ctrl_tb;
    logic core_clk, rst, vin_above_por, vin_above_headroom, input_overvoltage;
    logic vbat_above_3v0, vbat_above_3v2, vbat_at_4v2, vbat_above_recharge;
    logic ibat_below_termination, battery_present, rail_below_sharing;
    logic rail_below_battery, charge_enable_n, termination_select;
    logic source_type_select, usb_mode, charge_status_n_out;
    logic charge_status_n_oe, supply_good_n_out, supply_good_n_oe;
    logic rail_target_fixed, charge_on, trickle_current, cv_mode;
    logic termination_ratio, path_sharing, battery_path_switch;
    logic input_sag_throttle, timeout_fault;
    logic [2:0] phase;
    wire logic status_pin, good_pin;
    int   err_count = 0;
    int   cmp_count = 0;
    int   n;
    // timeout shortened to 400 ticks, yet one whole charge cycle still fits before it
    csc_charge_ctrl #(.TICK_CYC(10), .TIMEOUT_TICKS(400))
        i_csc_charge_ctrl (.*);
    csc_led_model i_csc_led_model (.status_oe(charge_status_n_oe),
        .status_drv(charge_status_n_out), .good_oe(supply_good_n_oe),
        .good_drv(supply_good_n_out), .status_pin(status_pin),
        .good_pin(good_pin));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    ////////////////////////////////////////
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
    endtask
    task automatic look;
        @(negedge core_clk);
    endtask
    task automatic chk(input logic [2:0] got, input logic [2:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // bounded wait for the status pin, counted in cycles
    task automatic wait_pin(input logic exp, input int lim, output int k);
        k = 0;
        while (status_pin !== exp && k < lim) begin
            @(negedge core_clk);
            k++;
        end
        if (status_pin !== exp) begin
            err_count++;
            $display("BAD %0t status pin stuck", $time);
            give_verdict;
        end
    endtask
    // power good, battery flat, adapter source; strap set before release
    task automatic do_reset(input logic strap);
        rst <= 1'b1;
        termination_select <= strap;
        {vin_above_por, vin_above_headroom, battery_present} <= 3'h7;
        {input_overvoltage, charge_enable_n, usb_mode} <= 3'h0;
        {vbat_above_3v0, vbat_above_3v2, vbat_at_4v2} <= 3'h0;
        {vbat_above_recharge, ibat_below_termination} <= 2'h0;
        {rail_below_sharing, rail_below_battery} <= 2'h0;
        source_type_select <= 1'b1;
        cyc(12);
        rst <= 1'b0;
    endtask
    ////////////////////////////////////////
    task automatic t_charge_flow;
        cyc(3);
        look;
        chk({trickle_current, rail_target_fixed, good_pin}, 3'h6);
        chk(phase, 3'h1);
        wait_pin(1'b0, 300, n);
        chk(n > 230, 1'b1);
        cyc(1);
        vbat_above_3v0 <= 1'b1;
        cyc(3);
        look;
        chk({trickle_current, phase[1:0]}, 3'h2);
        cyc(1);
        vbat_above_3v2 <= 1'b1;
        vbat_at_4v2 <= 1'b1;
        rail_below_sharing <= 1'b1;
        rail_below_battery <= 1'b1;
        cyc(3);
        look;
        chk({rail_target_fixed, cv_mode, phase[0]}, 3'h3);
        chk({path_sharing, battery_path_switch}, 3'h3);
    endtask
    task automatic t_end_of_charge;
        cyc(1);
        {rail_below_sharing, rail_below_battery} <= 2'h0;
        ibat_below_termination <= 1'b1;
        cyc(300);
        look;
        chk(status_pin, 1'b0);
        cyc(1);
        vbat_above_recharge <= 1'b1;
        wait_pin(1'b1, 300, n);
        chk(n > 230, 1'b1);
        cyc(3);
        look;
        chk(phase, 3'h4);
        cyc(1);
        {vbat_above_recharge, ibat_below_termination} <= 2'h0;
        cyc(3200);
        look;
        chk({charge_on, timeout_fault, status_pin}, 3'h5);
        cyc(1);
        charge_enable_n <= 1'b1;
        cyc(5);
        charge_enable_n <= 1'b0;
        wait_pin(1'b0, 300, n);
    endtask
    task automatic t_timeout;
        do_reset(1'b0);
        cyc(3900);
        look;
        chk(timeout_fault, 1'b0);
        cyc(200);
        look;
        chk({timeout_fault, charge_on, status_pin}, 3'h5);
        wait_pin(1'b0, 5100, n);
        wait_pin(1'b1, 5100, n);
        chk(n > 4990 && n < 5010, 1'b1);
        cyc(1);
        rail_below_battery <= 1'b1;
        charge_enable_n <= 1'b1;
        cyc(5);
        charge_enable_n <= 1'b0;
        cyc(5);
        look;
        chk({timeout_fault, battery_path_switch}, 3'h3);
        cyc(1);
        vin_above_por <= 1'b0;
        cyc(5);
        vin_above_por <= 1'b1;
        cyc(5);
        look;
        chk(timeout_fault, 1'b0);
    endtask
    task automatic t_strap_high;
        do_reset(1'b1);
        cyc(1);
        termination_select <= 1'b0;
        cyc(4500);
        look;
        chk(timeout_fault, 1'b0);
        cyc(1);
        {vbat_above_recharge, ibat_below_termination} <= 2'h3;
        wait_pin(1'b1, 300, n);
        cyc(3);
        look;
        chk(charge_on, 1'b1);
        for (int i = 0; i < 4; i++) begin
            cyc(1);
            {source_type_select, usb_mode} <= i[1:0];
            cyc(3);
            look;
            chk({termination_ratio, input_sag_throttle},
                {i == 0, !i[1]});
        end
        cyc(1);
        input_overvoltage <= 1'b1;
        cyc(3);
        look;
        chk({charge_on, good_pin}, 3'h1);
    endtask
    ////////////////////////////////////////
    initial begin
        do_reset(1'b0);
        t_charge_flow;
        t_end_of_charge;
        t_timeout;
        t_strap_high;
        give_verdict;
    end
endmodule // csc_charge_ctrl_tb
bind csc_charge_ctrl csc_checker #(.TICK_CYC(TICK_CYC)) i_csc_checker (.*);
`default_nettype wire
